// File: rtl/ccm_pkg.sv
package ccm_pkg;
	localparam logic [7:0] CONTROL_FLAGS_ADDR = 8'hd8;
	localparam logic [7:0] MODE_SELECT_ADDR = 8'hd9;
	localparam logic [7:0] CONTROL_FLAGS_RESET = 8'h00;
	localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
	localparam int OVERFLOW_FLAG_BIT = 7;
	localparam int RUN_BIT = 6;
	localparam int MODULE_FLAG_LSB = 0;
	localparam int IDLE_SUSPEND_BIT = 7;
	localparam int TIMEBASE_LSB = 1;
	localparam int TIMEBASE_MSB = 3;
	localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
	localparam int COUNTER_WIDTH = 16;
	localparam logic [15:0] COUNTER_MAX = 16'hffff;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [2:0] TB_SYSCLK_DIV12 = 3'h0;
	localparam logic [2:0] TB_SYSCLK_DIV4 = 3'h1;
	localparam logic [2:0] TB_TIMER0_OVERFLOW = 3'h2;
	localparam logic [2:0] TB_EXTERNAL_FALL = 3'h3;
	localparam logic [2:0] TB_SYSCLK = 3'h4;
	localparam logic [2:0] TB_EXTCLK_DIV8 = 3'h5;
	localparam logic [2:0] TB_LFOSC_DIV8 = 3'h6;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

// File: rtl/ccm_timebase.sv
`timescale 1ns/10ps
module ccm_timebase (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] timebaseSelect,
	input wire logic timer0Overflow,
	input wire logic externalCountInput,
	input wire logic extClockIn,
	input wire logic lfoscClockIn,
	output logic tick
);
	logic [3:0] div12;
	logic [1:0] div4;
	logic [2:0] extDiv;
	logic [2:0] lfDiv;
	logic eciPrev;
	logic extPrev;
	logic lfPrev;
	logic eciFall;
	logic extRise;
	logic lfRise;
	logic next_tick;

	assign eciFall = eciPrev && !externalCountInput;
	assign extRise = !extPrev && extClockIn;
	assign lfRise = !lfPrev && lfoscClockIn;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eciPrev <= 1'b1;
			extPrev <= 1'b0;
			lfPrev <= 1'b0;
		end else begin
			eciPrev <= externalCountInput;
			extPrev <= extClockIn;
			lfPrev <= lfoscClockIn;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div12 <= 4'h0;
			div4 <= 2'h0;
		end else begin
			div12 <= (div12 == ccm_pkg::DIV12_LAST) ? 4'h0 : div12 + 4'h1;
			div4 <= div4 + 2'h1;
		end
	end

	// Slow clocks are counted on their sampled rising edges in the system domain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			extDiv <= 3'h0;
			lfDiv <= 3'h0;
		end else begin
			if (extRise) begin
				extDiv <= extDiv + 3'h1;
			end
			if (lfRise) begin
				lfDiv <= lfDiv + 3'h1;
			end
		end
	end

	always_comb begin
		next_tick = 1'b0;
		unique case (timebaseSelect)
			ccm_pkg::TB_SYSCLK_DIV12: next_tick = (div12 == ccm_pkg::DIV12_LAST);
			ccm_pkg::TB_SYSCLK_DIV4: next_tick = (div4 == ccm_pkg::DIV4_LAST);
			ccm_pkg::TB_TIMER0_OVERFLOW: next_tick = timer0Overflow;
			ccm_pkg::TB_EXTERNAL_FALL: next_tick = eciFall;
			ccm_pkg::TB_SYSCLK: next_tick = 1'b1;
			ccm_pkg::TB_EXTCLK_DIV8: next_tick = extRise && (extDiv == ccm_pkg::DIV8_LAST);
			ccm_pkg::TB_LFOSC_DIV8: next_tick = lfRise && (lfDiv == ccm_pkg::DIV8_LAST);
			// Code 7 has no source, so the counter never advances
			default: next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick <= 1'b0;
		end else begin
			tick <= next_tick;
		end
	end
endmodule // ccm_timebase

// File: rtl/ccm_counter_control.sv
`timescale 1ns/10ps
module ccm_counter_control #(
	parameter int MODULES = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	input wire logic cpuIdle,
	input wire logic timer0Overflow,
	input wire logic externalCountInput,
	input wire logic extClockIn,
	input wire logic lfoscClockIn,
	input wire logic [MODULES-1:0] moduleCaptureEvent,
	input wire logic [MODULES-1:0] modulePwmMode,
	input wire logic [MODULES-1:0] matchFlagEnable,
	input wire logic [MODULES-1:0] moduleMatchEdge,
	input wire logic [MODULES-1:0] moduleUpEdge,
	input wire logic [MODULES-1:0] moduleIrqEnable,
	output logic [15:0] counterValue,
	output logic counterTick,
	output logic overflowIrq,
	output logic [MODULES-1:0] moduleIrq,
	output logic cpuIrqRequest
);
	if (MODULES < 1 || MODULES > 6) begin : g_check
		$error("MODULES must be between 1 and 6");
	end
	// Module flags share the control byte with the run bit, so they must stay below it
	if (ccm_pkg::MODULE_FLAG_LSB + MODULES > ccm_pkg::RUN_BIT) begin : g_check_layout
		$error("Module flags overlap the run bit");
	end
	if (ccm_pkg::TIMEBASE_MSB - ccm_pkg::TIMEBASE_LSB != 2) begin : g_check_select
		$error("Timebase select field must be three bits wide");
	end
	// The wrap compare is only right when the counter and its maximum agree in width
	if (ccm_pkg::COUNTER_WIDTH != $bits(ccm_pkg::COUNTER_MAX)) begin : g_check_width
		$error("Counter width does not match the wrap value");
	end

	logic overflowFlag;
	logic runBit;
	logic [MODULES-1:0] moduleFlag;
	logic idleSuspend;
	logic [2:0] timebaseSelect;
	logic overflowIrqEnable;
	logic baseTick;
	logic counting;
	logic wrapEvent;
	logic writeControl;
	logic writeMode;
	logic [MODULES-1:0] moduleSet;
	logic [MODULES-1:0] next_moduleFlag;
	logic next_overflowFlag;
	logic [7:0] next_rdata;
	logic idleStall;
	logic overflowRequest;
	logic [MODULES-1:0] moduleRequest;
	logic [7:0] controlWord;
	logic [7:0] modeWord;

	// Address compare shared by the write strobes and the read select
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	assign writeControl = sfrWrite && hits(sfrAddr, ccm_pkg::CONTROL_FLAGS_ADDR);
	assign writeMode = sfrWrite && hits(sfrAddr, ccm_pkg::MODE_SELECT_ADDR);

	ccm_timebase u_timebase (
		.clk(clk),
		.resetn(resetn),
		.timebaseSelect(timebaseSelect),
		.timer0Overflow(timer0Overflow),
		.externalCountInput(externalCountInput),
		.extClockIn(extClockIn),
		.lfoscClockIn(lfoscClockIn),
		.tick(baseTick)
	);

	assign idleStall = idleSuspend && cpuIdle;
	assign counting = baseTick && runBit && !idleStall;
	assign wrapEvent = counting && (counterValue == ccm_pkg::COUNTER_MAX);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			counterValue <= ccm_pkg::COUNTER_RESET;
		end else if (counting) begin
			counterValue <= counterValue + 16'h0001;
		end
	end

	// Tick rises on the same edge that shows the new count value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			counterTick <= 1'b0;
		end else begin
			counterTick <= counting;
		end
	end

	// Hardware set beats a software clear landing in the same cycle
	assign next_overflowFlag = wrapEvent ||
		(writeControl ? sfrWdata[ccm_pkg::OVERFLOW_FLAG_BIT] : overflowFlag);

	for (genvar i = 0; i < MODULES; i++) begin : g_module
		assign moduleSet[i] = moduleCaptureEvent[i] ||
			(modulePwmMode[i] && matchFlagEnable[i] &&
			(moduleMatchEdge[i] || moduleUpEdge[i]));
		assign next_moduleFlag[i] = moduleSet[i] ||
			(writeControl ? sfrWdata[ccm_pkg::MODULE_FLAG_LSB + i] : moduleFlag[i]);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overflowFlag <= ccm_pkg::CONTROL_FLAGS_RESET[ccm_pkg::OVERFLOW_FLAG_BIT];
		end else begin
			overflowFlag <= next_overflowFlag;
		end
	end

	// Run is plain storage; the counter first obeys it one edge after the write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			runBit <= ccm_pkg::CONTROL_FLAGS_RESET[ccm_pkg::RUN_BIT];
		end else if (writeControl) begin
			runBit <= sfrWdata[ccm_pkg::RUN_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			moduleFlag <= ccm_pkg::CONTROL_FLAGS_RESET[ccm_pkg::MODULE_FLAG_LSB +: MODULES];
		end else begin
			moduleFlag <= next_moduleFlag;
		end
	end

	// Reserved mode bits are not stored and always read as zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idleSuspend <= ccm_pkg::MODE_SELECT_RESET[ccm_pkg::IDLE_SUSPEND_BIT];
			timebaseSelect <= ccm_pkg::MODE_SELECT_RESET[ccm_pkg::TIMEBASE_MSB:ccm_pkg::TIMEBASE_LSB];
			overflowIrqEnable <= ccm_pkg::MODE_SELECT_RESET[ccm_pkg::OVERFLOW_IRQ_ENABLE_BIT];
		end else if (writeMode) begin
			idleSuspend <= sfrWdata[ccm_pkg::IDLE_SUSPEND_BIT];
			timebaseSelect <= sfrWdata[ccm_pkg::TIMEBASE_MSB:ccm_pkg::TIMEBASE_LSB];
			overflowIrqEnable <= sfrWdata[ccm_pkg::OVERFLOW_IRQ_ENABLE_BIT];
		end
	end

	// Each register image is built on its own so the read select stays a plain mux
	always_comb begin
		controlWord = 8'h00;
		controlWord[ccm_pkg::OVERFLOW_FLAG_BIT] = overflowFlag;
		controlWord[ccm_pkg::RUN_BIT] = runBit;
		controlWord[ccm_pkg::MODULE_FLAG_LSB +: MODULES] = moduleFlag;
	end

	always_comb begin
		modeWord = 8'h00;
		modeWord[ccm_pkg::IDLE_SUSPEND_BIT] = idleSuspend;
		modeWord[ccm_pkg::TIMEBASE_MSB:ccm_pkg::TIMEBASE_LSB] = timebaseSelect;
		modeWord[ccm_pkg::OVERFLOW_IRQ_ENABLE_BIT] = overflowIrqEnable;
	end

	// Unmapped addresses read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (hits(sfrAddr, ccm_pkg::CONTROL_FLAGS_ADDR)) begin
			next_rdata = controlWord;
		end else if (hits(sfrAddr, ccm_pkg::MODE_SELECT_ADDR)) begin
			next_rdata = modeWord;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sfrRdata <= 8'h00;
		end else if (sfrRead) begin
			sfrRdata <= next_rdata;
		end
	end

	assign overflowRequest = overflowFlag && overflowIrqEnable;
	assign moduleRequest = moduleFlag & moduleIrqEnable;

	// Requests follow the stored flags one cycle later so that outputs stay registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overflowIrq <= 1'b0;
		end else begin
			overflowIrq <= overflowRequest;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			moduleIrq <= '0;
		end else begin
			moduleIrq <= moduleRequest;
		end
	end

	// Built from the same terms as the two outputs above, so it never leads or trails them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuIrqRequest <= 1'b0;
		end else begin
			cpuIrqRequest <= overflowRequest || (|moduleRequest);
		end
	end
endmodule // ccm_counter_control

// File: tb/ccm_source_model.sv
`timescale 1ns/10ps
module ccm_source_model (
	input wire logic clk,
	output logic timer0Overflow = 1'b0,
	output logic externalCountInput = 1'b1,
	output logic extClockIn = 1'b0,
	output logic lfoscClockIn = 1'b0
);
	int n = 0;
	// Source periods 5, 6, 4, 6: only the period 4 is a multiple of a prescaler length (the divide-by-4)
	always @(negedge clk) begin
		n <= n + 1;
		timer0Overflow <= (n % 5) == 0;
		externalCountInput <= (n % 6) < 3;
		extClockIn <= (n % 4) < 2;
		lfoscClockIn <= (n % 6) < 3;
	end
endmodule // ccm_source_model

// File: tb/ccm_counter_control_chk.sv
`timescale 1ns/10ps
module ccm_counter_control_chk #(
	parameter int MODULES = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic cpuIdle,
	input wire logic [MODULES-1:0] modulePwmMode,
	input wire logic [MODULES-1:0] matchFlagEnable,
	input wire logic [MODULES-1:0] moduleUpEdge,
	input wire logic [MODULES-1:0] moduleIrqEnable,
	input wire logic [15:0] counterValue,
	input wire logic counterTick,
	input wire logic overflowIrq,
	input wire logic [MODULES-1:0] moduleIrq,
	input wire logic cpuIrqRequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic idleSh, ecfSh, runSh;
	// Shadow of the idle suspend, overflow enable and run bits, rebuilt from the writes the bus carries
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{idleSh, ecfSh, runSh} <= 3'h0;
		end else if (sfrWrite && sfrAddr == ccm_pkg::MODE_SELECT_ADDR) begin
			{idleSh, ecfSh} <= {sfrWdata[7], sfrWdata[0]};
		end else if (sfrWrite && sfrAddr == ccm_pkg::CONTROL_FLAGS_ADDR) begin
			runSh <= sfrWdata[6];
		end
	end
	sequence s_flag_set;
		(modulePwmMode[2] && matchFlagEnable[2] && moduleUpEdge[2] && moduleIrqEnable[2])
			##1 moduleIrqEnable[2];
	endsequence
	a_step_by_one: assert property ($changed(counterValue) |-> counterValue == $past(counterValue) + 16'h1) else $error("counter jump");
	a_tick_follows: assert property ($changed(counterValue) |-> counterTick) else $error("no tick");
	a_run_hold: assert property (!runSh |=> $stable(counterValue)) else $error("counts stopped");
	a_idle_hold: assert property (idleSh && cpuIdle |=> $stable(counterValue)) else $error("counts idle");
	a_ovf_mask: assert property (!ecfSh |=> !overflowIrq) else $error("masked irq");
	a_wrap_irq: assert property ($past(counterValue) == 16'hffff && counterValue == 16'h0000 && ecfSh |=> overflowIrq) else $error("wrap irq");
	a_module_mask: assert property ((moduleIrq & ~$past(moduleIrqEnable)) == '0) else $error("module mask");
	a_flag_irq: assert property (s_flag_set |=> moduleIrq[2]) else $error("pwm flag");
	a_irq_or: assert property (cpuIrqRequest == (overflowIrq || (|moduleIrq))) else $error("cpu irq");
	a_read_stands: assert property (!sfrRead |=> $stable(sfrRdata)) else $error("rdata moved");
endmodule // ccm_counter_control_chk
bind ccm_counter_control ccm_counter_control_chk #(.MODULES(MODULES)) chk (.clk, .resetn, .sfrAddr,
	.sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .cpuIdle, .modulePwmMode, .matchFlagEnable,
	.moduleUpEdge, .moduleIrqEnable, .counterValue, .counterTick, .overflowIrq, .moduleIrq,
	.cpuIrqRequest);

// File: tb/ccm_counter_control_bench.sv
`timescale 1ns/10ps
module ccm_counter_control_bench;
	logic clk = 1'b0, resetn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, cpuIdle = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
	logic [5:0] moduleCaptureEvent = 6'h00, modulePwmMode = 6'h00, matchFlagEnable = 6'h00;
	logic [5:0] moduleMatchEdge = 6'h00, moduleUpEdge = 6'h00, moduleIrqEnable = 6'h00, moduleIrq;
	logic [15:0] counterValue, v;
	logic counterTick, overflowIrq, cpuIrqRequest, timer0Overflow, externalCountInput;
	logic extClockIn, lfoscClockIn;
	int mismatches = 0, totalChecks = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	ccm_counter_control uut (.clk, .resetn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
		.cpuIdle, .timer0Overflow, .externalCountInput, .extClockIn, .lfoscClockIn,
		.moduleCaptureEvent, .modulePwmMode, .matchFlagEnable, .moduleMatchEdge, .moduleUpEdge,
		.moduleIrqEnable, .counterValue, .counterTick, .overflowIrq, .moduleIrq, .cpuIrqRequest);
	ccm_source_model src (.clk, .timer0Overflow, .externalCountInput, .extClockIn, .lfoscClockIn);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{sfrAddr, sfrWdata, sfrWrite} = {a, d, 1'b1};
		@(negedge clk);
		sfrWrite = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		{sfrAddr, sfrRead} = {a, 1'b1};
		@(negedge clk);
		sfrRead = 1'b0;
		chk(16'(sfrRdata), 16'(e));
		@(negedge clk);
	endtask
	task automatic testRegs();
		wr(8'hd0, 8'hff);
		rd(8'hd8, 8'h00);
		rd(8'hd9, 8'h00);
		rd(8'hd0, 8'h00);
		wr(8'hd9, 8'hff);
		rd(8'hd9, 8'h8f);
	endtask
	task automatic testTimebase();
		int c;
		int per [8] = '{12, 4, 5, 6, 1, 32, 48, 100};
		wr(8'hd8, 8'h40);
		for (int s = 0; s < 8; s++) begin
			wr(8'hd9, 8'(s << 1));
			repeat (3) @(negedge clk);
			for (c = 0; c < 100 && counterTick !== 1'b1; c++) @(negedge clk);
			@(negedge clk);
			for (c = 1; c < 100 && counterTick !== 1'b1; c++) @(negedge clk);
			chk(16'(c), 16'(per[s]));
		end
	endtask
	task automatic testHold();
		wr(8'hd9, 8'h88);
		cpuIdle = 1'b1;
		v = counterValue;
		repeat (10) @(negedge clk);
		chk(counterValue, v);
		wr(8'hd9, 8'h08);
		repeat (10) @(negedge clk);
		chk(16'(counterValue != v), 16'h1);
		cpuIdle = 1'b0;
		wr(8'hd8, 8'h00);
		v = counterValue;
		repeat (10) @(negedge clk);
		chk(counterValue, v);
	endtask
	task automatic testWrap();
		wr(8'hd9, 8'h09);
		wr(8'hd8, 8'h40);
		for (int c = 0; c < 70000 && overflowIrq !== 1'b1; c++) @(negedge clk);
		chk(16'({overflowIrq, cpuIrqRequest}), 16'h3);
		rd(8'hd8, 8'hc0);
		wr(8'hd9, 8'h08);
		@(negedge clk);
		chk(16'(overflowIrq), 16'h0);
		rd(8'hd8, 8'hc0);
		wr(8'hd8, 8'h00);
	endtask
	task automatic testFlags();
		{moduleIrqEnable, modulePwmMode, matchFlagEnable, moduleUpEdge} = {4{6'h04}};
		@(negedge clk);
		moduleUpEdge = 6'h00;
		@(negedge clk);
		chk(16'(moduleIrq), 16'h4);
		chk(16'(cpuIrqRequest), 16'h1);
		{moduleCaptureEvent, moduleMatchEdge} = {6'h20, 6'h02};
		@(negedge clk);
		{moduleCaptureEvent, moduleMatchEdge} = 12'h000;
		rd(8'hd8, 8'h24);
		chk(16'(moduleIrq), 16'h4);
		wr(8'hd8, 8'h00);
		rd(8'hd8, 8'h00);
		{modulePwmMode, matchFlagEnable, moduleMatchEdge} = {6'h09, 6'h01, 6'h09};
		@(negedge clk);
		moduleMatchEdge = 6'h00;
		rd(8'hd8, 8'h01);
		{moduleCaptureEvent, sfrAddr, sfrWdata, sfrWrite} = {6'h10, 8'hd8, 8'h00, 1'b1};
		@(negedge clk);
		{moduleCaptureEvent, sfrWrite} = 7'h00;
		@(negedge clk);
		rd(8'hd8, 8'h10);
	endtask
	task automatic testDone();
		$display("checks=%0d mismatches=%0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		testDone();
	end
	initial begin
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		testRegs();
		testTimebase();
		testHold();
		testWrap();
		testFlags();
		testDone();
	end
endmodule // ccm_counter_control_bench
